// [include/ea_decode_pkg.sv]
// Purpose: Shared types and constants for the effective-address decoder
// Assumes: 5-bit address field, 25 MHz core clock
// Notes:   Cycle figures are addressing and correction costs in machine cycles
package ea_decode_pkg;

   localparam logic [4:0] CODE_REG_LAST   = 5'h07;
   localparam logic [4:0] CODE_IND_LAST   = 5'h0B;
   localparam logic [4:0] CODE_POST_LAST  = 5'h0F;
   localparam logic [4:0] CODE_D8_LAST    = 5'h17;
   localparam logic [4:0] CODE_D16_LAST   = 5'h1B;
   localparam logic [4:0] CODE_IDX0       = 5'h1C;
   localparam logic [4:0] CODE_IDX1       = 5'h1D;
   localparam logic [4:0] CODE_PC_REL     = 5'h1E;
   localparam logic [4:0] CODE_DIRECT     = 5'h1F;

   localparam logic [1:0] EXT_NONE        = 2'h0;
   localparam logic [1:0] EXT_SHORT       = 2'h1;
   localparam logic [1:0] EXT_LONG        = 2'h2;

   localparam logic [2:0] CYC_INDIRECT    = 3'h1;
   localparam logic [2:0] CYC_POST_INC    = 3'h4;
   localparam logic [2:0] CYC_DISP        = 3'h1;
   localparam logic [2:0] CYC_INDEX       = 3'h2;
   localparam logic [2:0] CYC_PC_REL      = 3'h2;
   localparam logic [2:0] CYC_DIRECT      = 3'h1;

   localparam logic [2:0] CORR_NONE       = 3'h0;
   localparam logic [2:0] CORR_RAM_WORD   = 3'h1;
   localparam logic [2:0] CORR_RAM_LONG   = 3'h2;
   localparam logic [2:0] CORR_SLOW_BYTE  = 3'h1;
   localparam logic [2:0] CORR_EVEN_WORD  = 3'h1;
   localparam logic [2:0] CORR_EVEN_LONG  = 3'h2;
   localparam logic [2:0] CORR_SPLIT_WORD = 3'h3;
   localparam logic [2:0] CORR_SPLIT_LONG = 3'h6;

   localparam logic [1:0] ACC_USE_RESET   = 2'h0;

   localparam logic [2:0] INDEX_REG_NUM   = 3'h7;

   typedef enum logic [3:0] {
      MODE_REG_DIRECT,
      MODE_INDIRECT,
      MODE_POST_INC,
      MODE_SHORT_OFFSET,
      MODE_LONG_OFFSET,
      MODE_INDEXED,
      MODE_PC_REL,
      MODE_DIRECT
   } ea_mode_t;

   typedef enum logic [1:0] {
      SIZE_BYTE,
      SIZE_WORD,
      SIZE_LONG
   } op_size_t;

   typedef enum logic [1:0] {
      LOC_INT_REG,
      LOC_INT_RAM,
      LOC_OTHER,
      LOC_BUS8
   } op_loc_t;

   // Request from the instruction decoder
   typedef struct packed {
      logic [4:0] code;
      op_size_t   size;
      op_loc_t    loc;
      logic       odd_addr;
      logic [3:0] base_len;
      logic [5:0] base_cycles;
      logic [3:0] base_corr;
   } ea_req_t;

   // Answer to the sequencer and address generator
   typedef struct packed {
      ea_mode_t   mode;
      logic       is_memory;
      logic [2:0] ptr_reg;
      logic       use_index;
      logic [2:0] index_reg;
      logic [2:0] reg_num;
      logic       high_half;
      logic [1:0] ext_bytes;
      logic [2:0] addr_cycles;
      logic [2:0] corr_cycles;
      logic [4:0] instr_len;
      logic [6:0] total_cycles;
      logic [4:0] total_corr;
   } ea_rsp_t;

   localparam ea_rsp_t RSP_RESET = '0;

endpackage

// [logic/effective_address_decoder.sv]
// Purpose: Decode the effective-address field into mode, length and cycles
// Assumes: Inputs synchronous to clock; one request per valid cycle
// Notes:   Answer registered, valid one cycle after the request
`timescale 1ns/1ns
`default_nettype none

module effective_address_decoder
   import ea_decode_pkg::*;
(
   input  wire logic    clock,
   input  wire logic    reset,
   input  wire logic    enable,
   input  wire logic    req_valid,
   input  wire ea_req_t req,
   output logic         rsp_valid,
   output ea_rsp_t      rsp,
   output logic [1:0]   acc_half_use
);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode

   function automatic ea_mode_t decode_mode(input logic [4:0] code);
      ea_mode_t m;
      m = MODE_REG_DIRECT;
      if (code <= CODE_REG_LAST) begin
         m = MODE_REG_DIRECT;
      end else if (code <= CODE_IND_LAST) begin
         m = MODE_INDIRECT;
      end else if (code <= CODE_POST_LAST) begin
         m = MODE_POST_INC;
      end else if (code <= CODE_D8_LAST) begin
         m = MODE_SHORT_OFFSET;
      end else if (code <= CODE_D16_LAST) begin
         m = MODE_LONG_OFFSET;
      end else if (code == CODE_IDX0 || code == CODE_IDX1) begin
         m = MODE_INDEXED;
      end else if (code == CODE_PC_REL) begin
         m = MODE_PC_REL;
      end else begin
         m = MODE_DIRECT;
      end
      return m;
   endfunction

   function automatic logic [1:0] ext_count(input ea_mode_t m);
      logic [1:0] n;
      n = EXT_NONE;
      case (m)
         MODE_SHORT_OFFSET:  n = EXT_SHORT;
         MODE_LONG_OFFSET: n = EXT_LONG;
         MODE_PC_REL: n = EXT_LONG;
         MODE_DIRECT: n = EXT_LONG;
         default:     n = EXT_NONE;
      endcase
      return n;
   endfunction

   function automatic logic [2:0] addr_cost(input ea_mode_t m);
      logic [2:0] c;
      c = 3'h0;
      case (m)
         MODE_INDIRECT: c = CYC_INDIRECT;
         MODE_POST_INC: c = CYC_POST_INC;
         MODE_SHORT_OFFSET:    c = CYC_DISP;
         MODE_LONG_OFFSET:   c = CYC_DISP;
         MODE_INDEXED:  c = CYC_INDEX;
         MODE_PC_REL:   c = CYC_PC_REL;
         MODE_DIRECT:   c = CYC_DIRECT;
         // Register-direct cost is already in the instruction's base count
         default:       c = 3'h0;
      endcase
      return c;
   endfunction

   function automatic logic [2:0] corr_cost(input op_loc_t l, input op_size_t s,
                                            input logic odd);
      logic [2:0] c;
      c = CORR_NONE;
      case (l)
         LOC_INT_REG: c = CORR_NONE;
         LOC_INT_RAM: begin
            if (!odd || s == SIZE_BYTE) c = CORR_NONE;
            else if (s == SIZE_WORD) c = CORR_RAM_WORD;
            else c = CORR_RAM_LONG;
         end
         LOC_OTHER: begin
            if (s == SIZE_BYTE) c = CORR_SLOW_BYTE;
            else if (s == SIZE_WORD) c = odd ? CORR_SPLIT_WORD : CORR_EVEN_WORD;
            else c = odd ? CORR_SPLIT_LONG : CORR_EVEN_LONG;
         end
         LOC_BUS8: begin
            if (s == SIZE_BYTE) c = CORR_SLOW_BYTE;
            else if (s == SIZE_WORD) c = CORR_SPLIT_WORD;
            else c = CORR_SPLIT_LONG;
         end
         default: c = CORR_NONE;
      endcase
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Combinational answer

   ea_mode_t   mode_w;
   logic       mem_w;
   logic [2:0] ptr_w;
   logic [2:0] regn_w;
   logic       high_w;
   logic [1:0] ext_w;
   logic [2:0] acyc_w;
   logic [2:0] ccyc_w;
   ea_rsp_t    rsp_next;
   logic       valid_next;

   assign mode_w = decode_mode(req.code);
   assign mem_w  = (mode_w != MODE_REG_DIRECT);
   // Pointer field: low 3 bits for short_offset, low bit for indexed, low 2 bits elsewhere
   assign ptr_w  = (mode_w == MODE_SHORT_OFFSET) ? req.code[2:0] :
                   (mode_w == MODE_INDEXED) ? {2'b00, req.code[0]} :
                   {1'b0, req.code[1:0]};
   // Long registers pair adjacent codes; odd code is the upper half
   assign regn_w = (req.size == SIZE_LONG) ? {1'b0, req.code[2:1]} :
                   req.code[2:0];
   assign high_w = (req.size == SIZE_LONG) && req.code[0];
   assign ext_w  = ext_count(mode_w);
   assign acyc_w = addr_cost(mode_w);
   // Register operands never see memory correction
   assign ccyc_w = mem_w ? corr_cost(req.loc, req.size, req.odd_addr) : 3'h0;

   always_comb begin
      rsp_next              = RSP_RESET;
      rsp_next.mode         = mode_w;
      rsp_next.is_memory    = mem_w;
      rsp_next.ptr_reg      = mem_w ? ptr_w : 3'h0;
      rsp_next.use_index    = (mode_w == MODE_INDEXED);
      rsp_next.index_reg    = (mode_w == MODE_INDEXED) ? INDEX_REG_NUM : 3'h0;
      rsp_next.reg_num      = mem_w ? 3'h0 : regn_w;
      rsp_next.high_half    = mem_w ? 1'b0 : high_w;
      rsp_next.ext_bytes    = ext_w;
      rsp_next.addr_cycles  = acyc_w;
      rsp_next.corr_cycles  = ccyc_w;
      rsp_next.instr_len    = {1'b0, req.base_len} + {3'b000, ext_w};
      rsp_next.total_cycles = {1'b0, req.base_cycles} + {4'h0, acyc_w}
                              + {4'h0, ccyc_w};
      rsp_next.total_corr   = {1'b0, req.base_corr} + {2'b00, ccyc_w};
   end

   assign valid_next = req_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs; all fields update together

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rsp       <= RSP_RESET;
         rsp_valid <= 1'b0;
      end else if (enable) begin
         rsp_valid <= valid_next;
         if (req_valid) begin
            rsp <= rsp_next;
         end
      end
   end

   // Accumulator halves used: bit0 low half, bit1 high half
   logic [1:0] acc_next;
   assign acc_next = (req.size == SIZE_LONG) ? 2'h3 : 2'h1;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         acc_half_use <= ACC_USE_RESET;
      end else if (enable && req_valid) begin
         acc_half_use <= acc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_reg_class: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code <= CODE_REG_LAST)
      |=> (!rsp.is_memory && rsp.ext_bytes == 2'h0 && rsp.corr_cycles == 3'h0))
      else $error("register code decoded as memory");

   a_mem_class: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST) |=> rsp.is_memory)
      else $error("memory code decoded as register");

   a_long_half: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code <= CODE_REG_LAST && req.size == SIZE_LONG)
      |=> (rsp.high_half == $past(req.code[0]) && rsp.reg_num == $past(req.code[2:1])))
      else $error("long register pairing wrong");

   a_post_inc: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code[4:2] == 3'b011)
      |=> (rsp.mode == MODE_POST_INC && rsp.addr_cycles == 3'h4 && rsp.ext_bytes == 2'h0))
      else $error("post increment decode wrong");

   a_short_offset_ext: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code[4:3] == 2'b10)
      |=> (rsp.ext_bytes == 2'h1 && rsp.ptr_reg == $past(req.code[2:0])))
      else $error("short offset decode wrong");

   a_long_offset_ext: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code[4:2] == 3'b110) |=> rsp.ext_bytes == 2'h2)
      else $error("long offset extension wrong");

   a_index_mode: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code[4:1] == 4'hE)
      |=> (rsp.use_index && rsp.index_reg == 3'h7 && rsp.addr_cycles == 3'h2
           && rsp.ext_bytes == 2'h0))
      else $error("indexed decode wrong");

   a_pc_rel: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code == 5'h1E)
      |=> (rsp.mode == MODE_PC_REL && rsp.ext_bytes == 2'h2 && rsp.addr_cycles == 3'h2))
      else $error("pc relative decode wrong");

   a_direct_addr: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code == 5'h1F)
      |=> (rsp.ext_bytes == 2'h2 && rsp.addr_cycles == 3'h1))
      else $error("direct address decode wrong");

   a_instr_len: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid)
      |=> rsp.instr_len == {1'b0, $past(req.base_len)} + {3'b000, rsp.ext_bytes})
      else $error("instruction length wrong");

   a_bus8_long: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST && req.loc == LOC_BUS8
       && req.size == SIZE_LONG) |=> rsp.corr_cycles == 3'h6)
      else $error("narrow bus long correction wrong");

   a_odd_other: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST && req.loc == LOC_OTHER
       && req.odd_addr && req.size == SIZE_WORD) |=> rsp.corr_cycles == 3'h3)
      else $error("odd external word correction wrong");

   a_ram_odd: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST && req.loc == LOC_INT_RAM
       && req.odd_addr && req.size == SIZE_LONG) |=> rsp.corr_cycles == 3'h2)
      else $error("odd RAM long correction wrong");

   a_corr_both: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid)
      |=> (rsp.total_corr == {1'b0, $past(req.base_corr)} + {2'b00, rsp.corr_cycles}))
      else $error("correction term not applied");

   a_acc_long: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.size == SIZE_LONG) |=> acc_half_use == 2'b11)
      else $error("long accumulator use wrong");

   a_hold_frozen: assert property (@(posedge clock) disable iff (reset)
      (!enable) |=> $stable(rsp) && $stable(rsp_valid))
      else $error("outputs moved while frozen");

   a_indirect_cost: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code[4:2] == 3'h2)
      |=> (rsp.mode == MODE_INDIRECT && rsp.addr_cycles == 3'h1 && rsp.ext_bytes == 2'h0))
      else $error("plain indirect decode wrong");

   a_disp_cost: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code[4] && req.code[4:2] != 3'h7)
      |=> rsp.addr_cycles == 3'h1)
      else $error("offset addressing cost wrong");

   a_reg_no_cost: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code <= CODE_REG_LAST)
      |=> (rsp.addr_cycles == 3'h0 && rsp.total_cycles == {1'h0, $past(req.base_cycles)}))
      else $error("register operand given addressing cost");

   a_total_cycles: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid)
      |=> rsp.total_cycles == {1'h0, $past(req.base_cycles)} + {4'h0, rsp.addr_cycles}
                              + {4'h0, rsp.corr_cycles})
      else $error("cycle count not summed");

   a_int_reg_zero: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST && req.loc == LOC_INT_REG)
      |=> rsp.corr_cycles == 3'h0)
      else $error("internal register operand corrected");

   a_even_other: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST && req.loc == LOC_OTHER
       && !req.odd_addr && req.size == SIZE_LONG) |=> rsp.corr_cycles == 3'h2)
      else $error("even external long correction wrong");

   a_bus8_byte: assert property (@(posedge clock) disable iff (reset)
      (enable && req_valid && req.code > CODE_REG_LAST && req.loc == LOC_BUS8
       && req.size == SIZE_BYTE) |=> rsp.corr_cycles == 3'h1)
      else $error("narrow bus byte correction wrong");

   a_valid_pulse: assert property (@(posedge clock) disable iff (reset)
      (enable && !req_valid) |=> !rsp_valid)
      else $error("answer pulse without request");

endmodule

`default_nettype wire

// [tb/sequencer_model.sv]
// Purpose: Sequencer side that takes each decoder answer as it arrives
// Assumes: Answer fields qualified by rsp_valid in one cycle
// Notes:   Counts answers so the bench can match them to requests
`timescale 1ns/1ns
`default_nettype none

module sequencer_model
   import ea_decode_pkg::*;
(
   input  wire logic    clock,
   input  wire logic    reset,
   input  wire logic    enable,
   input  wire logic    rsp_valid,
   input  wire ea_rsp_t rsp,
   output logic [7:0]   seen_count,
   output ea_rsp_t      seen_rsp
);
   // Whole answer captured on one edge; a split answer would mix requests
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         seen_count <= 8'h00;
         seen_rsp   <= RSP_RESET;
      // Shares the core clock enable, so a pulse held by a freeze counts once
      end else if (enable && rsp_valid) begin
         seen_count <= seen_count + 8'h01;
         seen_rsp   <= rsp;
      end
   end
endmodule

`default_nettype wire

// [tb/tb_effective_address_decoder.sv]
// Purpose: Self-checking bench for the effective-address decoder
// Assumes: Answer one edge after each request, as handed over
// Notes:   Base length 2, base cycles 5, base correction 1 in every request
`timescale 1ns/1ns
`default_nettype none

`define CHECK(a, b, msg) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("mismatch at %0t: %s", $time, msg); end end

module tb_effective_address_decoder;
   import ea_decode_pkg::*;
   logic       clock;
   logic       reset;
   logic       enable;
   logic       req_valid;
   ea_req_t    req;
   logic       rsp_valid;
   ea_rsp_t    rsp;
   logic [1:0] acc_half_use;
   logic [7:0] seen_count;
   ea_rsp_t    seen_rsp;
   int         fails;
   int         check_count;
   int         cycles;
   int         sent;

   effective_address_decoder dut_u (
      .clock(clock), .reset(reset), .enable(enable), .req_valid(req_valid), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp), .acc_half_use(acc_half_use));
   sequencer_model partner_u (
      .clock(clock), .reset(reset), .enable(enable), .rsp_valid(rsp_valid), .rsp(rsp),
      .seen_count(seen_count), .seen_rsp(seen_rsp));

   ////////////////////////////////////////////////////////////////////////////
   function automatic ea_mode_t exp_mode(input logic [4:0] c);
      if (c <= 5'h07) return MODE_REG_DIRECT;
      if (c <= 5'h0B) return MODE_INDIRECT;
      if (c <= 5'h0F) return MODE_POST_INC;
      if (c <= 5'h17) return MODE_SHORT_OFFSET;
      if (c <= 5'h1B) return MODE_LONG_OFFSET;
      if (c <= 5'h1D) return MODE_INDEXED;
      if (c == 5'h1E) return MODE_PC_REL;
      return MODE_DIRECT;
   endfunction

   function automatic logic [1:0] exp_ext(input logic [4:0] c);
      if (c >= 5'h10 && c <= 5'h17) return 2'h1;
      if ((c >= 5'h18 && c <= 5'h1B) || c >= 5'h1E) return 2'h2;
      return 2'h0;
   endfunction

   function automatic logic [2:0] exp_cyc(input logic [4:0] c);
      if (c <= 5'h07) return 3'h0;
      if (c >= 5'h0C && c <= 5'h0F) return 3'h4;
      if (c >= 5'h1C && c <= 5'h1E) return 3'h2;
      return 3'h1;
   endfunction

   function automatic logic [2:0] exp_corr(input op_size_t s, input op_loc_t l, input logic o);
      case (l)
         LOC_INT_REG: return 3'h0;
         LOC_INT_RAM: return (s == SIZE_BYTE || !o) ? 3'h0 : (s == SIZE_WORD ? 3'h1 : 3'h2);
         LOC_OTHER:   return (s == SIZE_BYTE) ? 3'h1 : (s == SIZE_WORD ? (o ? 3'h3 : 3'h1)
                                                                     : (o ? 3'h6 : 3'h2));
         default:     return (s == SIZE_BYTE) ? 3'h1 : (s == SIZE_WORD ? 3'h3 : 3'h6);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [4:0] c, input op_size_t s, input op_loc_t l, input logic o);
      @(posedge clock);
      req_valid <= 1'b1;
      req       <= '{c, s, l, o, 4'h2, 6'h05, 4'h1};
      sent++;
      @(posedge clock);
      req_valid <= 1'b0;
      #1;
   endtask

   task automatic check_rsp(input logic [4:0] c, input op_size_t s, input op_loc_t l,
                            input logic o);
      logic       mem;
      logic [1:0] ext;
      logic [2:0] cyc;
      logic [2:0] corr;
      mem  = c > 5'h07;
      ext  = exp_ext(c);
      cyc  = exp_cyc(c);
      corr = mem ? exp_corr(s, l, o) : 3'h0;
      `CHECK(rsp_valid, 1'b1, "answer pulse missing")
      `CHECK(rsp.is_memory, mem, "operand class")
      `CHECK(rsp.mode, exp_mode(c), "mode")
      `CHECK(rsp.ext_bytes, ext, "extension bytes")
      `CHECK(rsp.addr_cycles, cyc, "addressing cycles")
      `CHECK(rsp.corr_cycles, corr, "correction cycles")
      `CHECK(rsp.instr_len, 5'h02 + 5'(ext), "length")
      `CHECK(rsp.total_cycles, 7'h05 + 7'(cyc) + 7'(corr), "total cycles")
      `CHECK(rsp.total_corr, 5'h01 + 5'(corr), "total correction")
      `CHECK(acc_half_use, (s == SIZE_LONG) ? 2'h3 : 2'h1, "accumulator use")
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_all_codes;
      for (int c = 0; c < 32; c++) begin
         send(5'(c), SIZE_WORD, LOC_OTHER, 1'b1);
         check_rsp(5'(c), SIZE_WORD, LOC_OTHER, 1'b1);
         if (c < 8) `CHECK(rsp.reg_num, 3'(c), "register number")
      end
   endtask

   task automatic t_corrections;
      for (int l = 0; l < 4; l++) begin
         for (int s = 0; s < 3; s++) begin
            for (int o = 0; o < 2; o++) begin
               send(CODE_DIRECT, op_size_t'(s), op_loc_t'(l), 1'(o));
               check_rsp(CODE_DIRECT, op_size_t'(s), op_loc_t'(l), 1'(o));
            end
         end
      end
   endtask

   task automatic t_registers;
      send(5'h03, SIZE_LONG, LOC_INT_REG, 1'b0);
      `CHECK(rsp.reg_num, 3'h1, "long register pair")
      `CHECK(rsp.high_half, 1'b1, "upper half")
      `CHECK(acc_half_use, 2'h3, "long uses both halves")
      send(5'h06, SIZE_LONG, LOC_INT_REG, 1'b0);
      `CHECK(rsp.reg_num, 3'h3, "even long register")
      `CHECK(rsp.high_half, 1'b0, "lower half")
      send(5'h05, SIZE_BYTE, LOC_BUS8, 1'b0);
      `CHECK(rsp.reg_num, 3'h5, "byte register")
      `CHECK(rsp.corr_cycles, 3'h0, "register operand corrected")
      `CHECK(acc_half_use, 2'h1, "byte uses low half")
      send(5'h0E, SIZE_BYTE, LOC_INT_RAM, 1'b1);
      `CHECK(rsp.ptr_reg, 3'h2, "post-increment pointer")
      send(5'h15, SIZE_WORD, LOC_INT_RAM, 1'b0);
      `CHECK(rsp.ptr_reg, 3'h5, "short offset pointer")
      send(5'h1D, SIZE_WORD, LOC_BUS8, 1'b0);
      `CHECK(rsp.ptr_reg, 3'h1, "indexed base")
      `CHECK(rsp.use_index, 1'b1, "index used")
      `CHECK(rsp.index_reg, 3'h7, "index register")
   endtask

   // Back to back, then a request while frozen must leave the answer alone
   task automatic t_back_to_back_freeze;
      @(posedge clock);
      req_valid <= 1'b1;
      req       <= '{5'h1E, SIZE_LONG, LOC_BUS8, 1'b0, 4'h2, 6'h05, 4'h1};
      sent++;
      @(posedge clock);
      req.code  <= 5'h10;
      sent++;
      #1;
      check_rsp(5'h1E, SIZE_LONG, LOC_BUS8, 1'b0);
      @(posedge clock);
      enable    <= 1'b0;
      req.code  <= 5'h0C;
      #1;
      check_rsp(5'h10, SIZE_LONG, LOC_BUS8, 1'b0);
      @(posedge clock);
      enable    <= 1'b1;
      req_valid <= 1'b0;
      #1;
      // A frozen edge holds the last pulse instead of ending it
      `CHECK(rsp_valid, 1'b1, "valid moved while frozen")
      `CHECK(rsp.mode, MODE_SHORT_OFFSET, "answer changed while frozen")
      @(posedge clock);
      #1;
      `CHECK(rsp_valid, 1'b0, "frozen request answered")
      `CHECK(rsp.mode, MODE_SHORT_OFFSET, "frozen request taken late")
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Whole run needs about 150 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         stop_test();
      end
   end

   initial begin
      reset     = 1'b1;
      enable    = 1'b1;
      req_valid = 1'b0;
      req       = '0;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      #1;
      `CHECK(rsp_valid, 1'b0, "valid after reset")
      `CHECK(rsp, RSP_RESET, "answer after reset")
      `CHECK(acc_half_use, 2'h0, "accumulator use after reset")
      t_all_codes();
      t_corrections();
      t_registers();
      t_back_to_back_freeze();
      @(posedge clock);
      #1;
      `CHECK(seen_count, 8'(sent), "answers taken by sequencer")
      `CHECK(seen_rsp, rsp, "sequencer copy of answer")
      stop_test();
   end
endmodule

`default_nettype wire
